// ### core/e1_interrupt_mask_and_code_detect.sv
// Implementation choice: the strobed register port.
`include "e1_irq_defs.svh"

module e1_interrupt_mask_and_code_detect
  import e1_irq_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [7:0] o_rd_data,
  input wire logic [7:0] i_evt_word0,
  input wire logic [7:0] i_evt_word1,
  input wire logic [7:0] i_rx_slot_data,
  input wire logic i_rx_slot_valid,
  input wire logic i_slot_detect_select,
  input wire logic i_serial_control_mode,
  output logic o_single_frame_buffer_sel,
  output logic o_transmit_signalling_mode,
  output logic o_register_signalling_sel,
  output logic o_bit_error_source_sel,
  output logic o_irq_b,
  output logic o_irq_oe
);

  // Class of each source; serves the vector readback, not the assertions
  function automatic byte_t vec_of(input byte_t p0, input byte_t p1,
                                   input logic pm);
    byte_t v;
    v = 8'h00;
    if (p0[7]) v = v | `VEC_SYNC;
    if (|p0[6:3]) v = v | `VEC_ALARM;
    if (p0[2]) v = v | `VEC_ERROR;
    if (p0[1]) v = v | `VEC_WRAP;
    if (p0[0]) v = v | `VEC_SLIP;
    if (|p1[7:2]) v = v | `VEC_ERROR;
    if (p1[0]) v = v | `VEC_SIG;
    if (pm) v = v | `VEC_MATCH;
    return v;
  endfunction

  function automatic logic hit(input byte_t data, input byte_t pat,
                               input byte_t msk);
    return ((data ^ pat) & msk) == 8'h00;
  endfunction

  byte_t pattern_q, pattern_d;
  byte_t bitmask_q, bitmask_d;
  byte_t ctrl_q, ctrl_d;
  byte_t mask0_q, mask0_d;
  byte_t mask1_q, mask1_d;
  logic arm_bit_q, arm_bit_d;
  logic match_en_q, match_en_d;
  byte_t pend0_q, pend0_d;
  byte_t pend1_q, pend1_d;
  logic pendm_q, pendm_d;
  det_state_t det_q, det_d;
  byte_t rd_q, rd_d;
  logic irq_oe_q, irq_oe_d;
  logic irq_b_q, irq_b_d;
  logic buf_q, buf_d;
  logic txsig_q, txsig_d;
  logic regsig_q, regsig_d;
  logic bersrc_q, bersrc_d;

  logic suspend;
  byte_t en0;
  byte_t en1;
  logic match_evt;
  logic wr_pend0;
  logic wr_pend1;
  logic wr_pendm;

  assign suspend = ctrl_q[`CTRL_SUSP_BIT];
  assign en0 = ~mask0_q;
  assign en1 = mask1_q & `MASK1_USED;
  assign wr_pend0 = i_wr_stb && i_addr == `OFF_PEND0;
  assign wr_pend1 = i_wr_stb && i_addr == `OFF_PEND1;
  assign wr_pendm = i_wr_stb && i_addr == `OFF_PENDM;
  // A match is a one-shot per arming
  assign match_evt = det_q == DET_ARMED && i_rx_slot_valid &&
                     i_slot_detect_select &&
                     hit(i_rx_slot_data, pattern_q, bitmask_q);

  // Register writes
  always_comb begin
    pattern_d = pattern_q;
    bitmask_d = bitmask_q;
    ctrl_d = ctrl_q;
    mask0_d = mask0_q;
    mask1_d = mask1_q;
    arm_bit_d = arm_bit_q;
    match_en_d = match_en_q;
    if (i_wr_stb) begin
      case (i_addr)
        `OFF_PATTERN: pattern_d = i_wr_data;
        `OFF_BITMASK: bitmask_d = i_wr_data;
        `OFF_CTRL: ctrl_d = i_wr_data & `CTRL_USED;
        `OFF_MASK0: mask0_d = i_wr_data;
        `OFF_MASK1: mask1_d = i_wr_data & `MASK1_USED;
        `OFF_ARM: begin
          arm_bit_d = i_wr_data[`ARM_GO_BIT];
          match_en_d = i_wr_data[`ARM_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pattern_q <= `RST_PATTERN;
      bitmask_q <= `RST_BITMASK;
      ctrl_q <= `RST_CTRL;
      mask0_q <= `RST_MASK0;
      mask1_q <= `RST_MASK1;
      arm_bit_q <= 1'b0;
      match_en_q <= 1'b0;
    end else begin
      pattern_q <= pattern_d;
      bitmask_q <= bitmask_d;
      ctrl_q <= ctrl_d;
      mask0_q <= mask0_d;
      mask1_q <= mask1_d;
      arm_bit_q <= arm_bit_d;
      match_en_q <= match_en_d;
    end
  end

  // Code detector: only a rising arm bit restarts the search
  always_comb begin
    det_d = det_q;
    case (det_q)
      DET_IDLE: if (arm_bit_d && !arm_bit_q) det_d = DET_ARMED;
      DET_ARMED: begin
        if (!arm_bit_q) det_d = DET_IDLE;
        else if (match_evt) det_d = DET_DONE;
      end
      DET_DONE: if (!arm_bit_q) det_d = DET_IDLE;
      default: det_d = DET_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) det_q <= DET_IDLE;
    else det_q <= det_d;
  end

  // Pending flags: a new event beats a same-cycle clear.
  // Suspend blocks new events so that nothing queues behind it.
  always_comb begin
    pend0_d = pend0_q;
    pend1_d = pend1_q;
    pendm_d = pendm_q;
    if (wr_pend0) pend0_d = pend0_d & ~i_wr_data;
    if (wr_pend1) pend1_d = pend1_d & ~i_wr_data;
    if (wr_pendm && i_wr_data[0]) pendm_d = 1'b0;
    if (!suspend) begin
      pend0_d = pend0_d | (i_evt_word0 & en0);
      pend1_d = pend1_d | (i_evt_word1 & en1);
      if (match_evt && match_en_q) pendm_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pend0_q <= 8'h00;
      pend1_q <= 8'h00;
      pendm_q <= 1'b0;
    end else begin
      pend0_q <= pend0_d;
      pend1_q <= pend1_d;
      pendm_q <= pendm_d;
    end
  end

  // Outputs and read data
  always_comb begin
    irq_oe_d = !suspend &&
               ((|(pend0_q & en0)) || (|(pend1_q & en1)) ||
                (pendm_q && match_en_q));
    buf_d = ctrl_q[`CTRL_BUF_BIT];
    txsig_d = ctrl_q[`CTRL_TXSIG_BIT];
    regsig_d = ctrl_q[`CTRL_REGSIG_BIT] && !i_serial_control_mode;
    bersrc_d = ctrl_q[`CTRL_BERSRC_BIT];
    irq_b_d = 1'b0;
    rd_d = 8'h00;
    if (i_rd_stb) begin
      case (i_addr)
        `OFF_PATTERN: rd_d = pattern_q;
        `OFF_BITMASK: rd_d = bitmask_q;
        `OFF_CTRL: rd_d = ctrl_q;
        `OFF_MASK0: rd_d = mask0_q;
        `OFF_MASK1: rd_d = mask1_q;
        `OFF_ARM: rd_d = {6'h00, match_en_q, arm_bit_q};
        `OFF_PEND0: rd_d = pend0_q;
        `OFF_PEND1: rd_d = pend1_q;
        `OFF_PENDM: rd_d = {6'h00, det_q == DET_ARMED, pendm_q};
        `OFF_VECTOR: rd_d = vec_of(pend0_q & en0, pend1_q & en1,
                                   pendm_q && match_en_q);
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_q <= 8'h00;
      irq_oe_q <= 1'b0;
      buf_q <= 1'b0;
      txsig_q <= 1'b0;
      regsig_q <= 1'b0;
      bersrc_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      irq_oe_q <= irq_oe_d;
      buf_q <= buf_d;
      txsig_q <= txsig_d;
      regsig_q <= regsig_d;
      bersrc_q <= bersrc_d;
      irq_b_q <= irq_b_d;
    end
  end

  // Open-drain request: the pin only ever pulls low
  assign o_irq_b = irq_b_q;
  assign o_irq_oe = irq_oe_q;
  assign o_rd_data = rd_q;
  assign o_single_frame_buffer_sel = buf_q;
  assign o_transmit_signalling_mode = txsig_q;
  assign o_register_signalling_sel = regsig_q;
  assign o_bit_error_source_sel = bersrc_q;

  match_sets_flag_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    match_evt && match_en_q && !suspend |=> pendm_q)
    else $error("pattern match did not set its flag");

  masked_bit_ignored_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    det_q == DET_ARMED && i_rx_slot_valid && i_slot_detect_select &&
    bitmask_q == 8'h00 |=> det_q != DET_ARMED)
    else $error("fully masked compare failed to match");

  buffer_select_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    ##1 o_single_frame_buffer_sel == $past(ctrl_q[7]))
    else $error("buffer select does not follow control");

  suspend_releases_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    suspend ##1 suspend |->
    !o_irq_oe && (pend0_q & ~$past(pend0_q)) == 8'h00)
    else $error("request active or flag set while suspended");

  regsig_serial_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_serial_control_mode |=> !o_register_signalling_sel)
    else $error("register signalling active in serial mode");

  mask0_enable_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !suspend && i_evt_word0[7] && !mask0_q[7] |=> pend0_q[7])
    else $error("enabled word zero source not latched");

  mask1_disable_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !pend1_q[0] && !mask1_q[0] |=> !pend1_q[0])
    else $error("disabled word one source latched");

  sync_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend0_q[7] && en0[7]
    |=> o_rd_data[7])
    else $error("sync loss vector missing");

  irq_follows_pend_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !suspend && (|(pend1_q & en1)) |=> o_irq_oe)
    else $error("request not raised for pending source");

  single_match_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    det_q == DET_DONE && arm_bit_q |=> det_q != DET_ARMED)
    else $error("detector rearmed without new arm edge");

  unselected_slot_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    det_q == DET_ARMED && arm_bit_q && !i_slot_detect_select
    |=> det_q == DET_ARMED)
    else $error("unselected slot ended the search");

  mismatch_kept_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    det_q == DET_ARMED && arm_bit_q && i_rx_slot_valid &&
    ((i_rx_slot_data ^ pattern_q) & bitmask_q) != 8'h00
    |=> det_q == DET_ARMED)
    else $error("mismatching slot ended the search");

  suspend_no_match_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    suspend && !pendm_q |=> !pendm_q)
    else $error("match flag set while suspended");

  txsig_follows_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    1'b1 |=> o_transmit_signalling_mode == $past(ctrl_q[4]))
    else $error("signalling mode does not follow control");

  regsig_follows_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !i_serial_control_mode |=> o_register_signalling_sel == $past(ctrl_q[3]))
    else $error("signalling source does not follow control");

  bersrc_follows_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    1'b1 |=> o_bit_error_source_sel == $past(ctrl_q[2]))
    else $error("error source does not follow control");

  mask0_disable_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !pend0_q[2] && mask0_q[2] |=> !pend0_q[2])
    else $error("disabled word zero source latched");

  mask1_enable_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !suspend && i_evt_word1[0] && mask1_q[0] |=> pend1_q[0])
    else $error("enabled word one source not latched");

  alarm_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && |(pend0_q[6:3] & en0[6:3])
    |=> o_rd_data[6])
    else $error("alarm vector missing");

  frame_err_vec_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend0_q[2] && en0[2]
    |=> o_rd_data[5])
    else $error("framing error vector missing");

  wrap_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend0_q[1] && en0[1]
    |=> o_rd_data[4])
    else $error("counter wrap vector missing");

  slip_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend0_q[0] && en0[0]
    |=> o_rd_data[2])
    else $error("slip vector missing");

  crc_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && |(pend1_q[7:6] & en1[7:6])
    |=> o_rd_data[5])
    else $error("crc error vector missing");

  double_fas_vec_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend1_q[5] && en1[5]
    |=> o_rd_data[5])
    else $error("double framing error vector missing");

  error_event_vec_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && |(pend1_q[4:2] & en1[4:2])
    |=> o_rd_data[5])
    else $error("error event vector missing");

  signal_vector_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    i_rd_stb && i_addr == `OFF_VECTOR && pend1_q[0] && en1[0]
    |=> o_rd_data[0])
    else $error("signalling change vector missing");

  irq_idle_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    !(|(pend0_q & en0)) && !(|(pend1_q & en1)) &&
    !(pendm_q && match_en_q) |=> !o_irq_oe)
    else $error("request raised with nothing pending");

  arm_edge_only_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    det_q == DET_IDLE && !(i_wr_stb && i_addr == `OFF_ARM)
    |=> det_q == DET_IDLE)
    else $error("detector armed without arm write");

endmodule

// ### core/e1_irq_defs.svh
`ifndef E1_IRQ_DEFS_SVH
`define E1_IRQ_DEFS_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFF_PATTERN 8'h18
`define OFF_BITMASK 8'h19
`define OFF_CTRL 8'h1A
`define OFF_MASK0 8'h1B
`define OFF_MASK1 8'h1C
`define OFF_ARM 8'h20
`define OFF_PEND0 8'h21
`define OFF_PEND1 8'h22
`define OFF_PENDM 8'h23
`define OFF_VECTOR 8'h24

`define RST_PATTERN 8'h00
`define RST_BITMASK 8'h00
`define RST_CTRL 8'h00
`define RST_MASK0 8'h00
`define RST_MASK1 8'h00

`define CTRL_USED 8'hDC
`define MASK1_USED 8'hFD

`define CTRL_BUF_BIT 7
`define CTRL_SUSP_BIT 6
`define CTRL_TXSIG_BIT 4
`define CTRL_REGSIG_BIT 3
`define CTRL_BERSRC_BIT 2

`define ARM_GO_BIT 0
`define ARM_EN_BIT 1

`define VEC_SYNC 8'h80
`define VEC_ALARM 8'h40
`define VEC_ERROR 8'h20
`define VEC_WRAP 8'h10
`define VEC_SLIP 8'h04
`define VEC_MATCH 8'h02
`define VEC_SIG 8'h01

`endif

// ### core/e1_irq_pkg.sv
package e1_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    DET_IDLE,
    DET_ARMED,
    DET_DONE
  } det_state_t;
endpackage

// ### tb/host_model.sv
module host_model (
  input wire logic i_ref_clk,
  output logic [7:0] o_addr,
  output logic [7:0] o_wr_data,
  output logic o_wr_stb,
  output logic o_rd_stb,
  input wire logic [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_addr = 8'h00;
    o_wr_data = 8'h00;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
  end
  // Released lines show the inverse so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    o_addr <= a;
    o_wr_data <= v;
    o_wr_stb <= 1'b1;
    @(posedge i_ref_clk);
    o_wr_stb <= 1'b0;
    o_addr <= ~a;
    o_wr_data <= ~v;
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    o_addr <= a;
    o_rd_stb <= 1'b1;
    @(posedge i_ref_clk);
    o_rd_stb <= 1'b0;
    o_addr <= ~a;
    @(posedge i_ref_clk);
    v = i_rd_data;
  endtask
endmodule

// ### tb/test_e1_interrupt_mask_and_code_detect.sv
`include "e1_irq_defs.svh"

module test_e1_interrupt_mask_and_code_detect
  import e1_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst_b, wr_stb, rd_stb, slot_valid, slot_sel, serial_mode;
  logic buf_sel, txsig, regsig, bersrc, irq_b, irq_oe;
  byte_t addr, wr_data, rd_data, evt0, evt1, slot_data, d, bit_v;
  int error_cnt = 0;
  int cmp_count = 0;
  // Index is word * 8 + bit; a zero vector marks a bit that cannot fire
  localparam byte_t ROWS [16] = '{8'h04, 8'h10, 8'h20, 8'h40, 8'h40, 8'h40,
    8'h40, 8'h80, 8'h01, 8'h00, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
  localparam byte_t OFFS [5] = '{`OFF_PATTERN, `OFF_BITMASK, `OFF_CTRL,
    `OFF_MASK0, `OFF_MASK1};
  always #2.5 ref_clk = ~ref_clk;
  host_model host_model_i (.i_ref_clk(ref_clk), .o_addr(addr),
    .o_wr_data(wr_data), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
    .i_rd_data(rd_data));
  e1_interrupt_mask_and_code_detect e1_interrupt_mask_and_code_detect_i (
    .i_ref_clk(ref_clk), .i_rst_b(rst_b), .i_addr(addr),
    .i_wr_data(wr_data), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .o_rd_data(rd_data), .i_evt_word0(evt0), .i_evt_word1(evt1),
    .i_rx_slot_data(slot_data), .i_rx_slot_valid(slot_valid),
    .i_slot_detect_select(slot_sel), .i_serial_control_mode(serial_mode),
    .o_single_frame_buffer_sel(buf_sel), .o_transmit_signalling_mode(txsig),
    .o_register_signalling_sel(regsig), .o_bit_error_source_sel(bersrc),
    .o_irq_b(irq_b), .o_irq_oe(irq_oe));
  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input byte_t got, input byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input byte_t a, input byte_t exp);
    host_model_i.rd(a, d);
    chk(d, exp);
  endtask
  task automatic pulse(input logic w, input byte_t ev);
    evt0 <= w ? 8'h00 : ev;
    evt1 <= w ? ev : 8'h00;
    @(posedge ref_clk);
    evt0 <= 8'h00;
    evt1 <= 8'h00;
    @(posedge ref_clk);
  endtask
  task automatic enable(input logic w, input byte_t ev, input logic on);
    host_model_i.wr(`OFF_MASK0, (!w && on) ? ~ev : 8'hFF);
    host_model_i.wr(`OFF_MASK1, (w && on) ? ev : 8'h00);
  endtask
  task automatic slot(input byte_t v, input logic s);
    slot_data <= v;
    slot_sel <= s;
    slot_valid <= 1'b1;
    @(posedge ref_clk);
    slot_valid <= 1'b0;
    slot_data <= ~v;
    @(posedge ref_clk);
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    {evt0, evt1, slot_data} = 24'h000000;
    {slot_valid, slot_sel, serial_mode} = 3'b000;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int k = 0; k < 5; k++) rdchk(OFFS[k], 8'h00);
    host_model_i.wr(8'h30, 8'hFF);
    rdchk(8'h30, 8'h00);
    host_model_i.wr(`OFF_MASK1, 8'hFF);
    rdchk(`OFF_MASK1, 8'hFD);
    for (int k = 0; k < 16; k++) begin
      bit_v = 8'h01 << (k % 8);
      enable(k / 8, bit_v, 1'b1);
      pulse(k / 8, bit_v);
      @(posedge ref_clk);
      chk({7'h00, irq_oe}, {7'h00, ROWS[k] != 8'h00});
      chk({7'h00, irq_b}, 8'h00);
      rdchk(`OFF_VECTOR, ROWS[k]);
      host_model_i.wr(k < 8 ? `OFF_PEND0 : `OFF_PEND1, bit_v);
      enable(k / 8, bit_v, 1'b0);
      pulse(k / 8, bit_v);
      @(posedge ref_clk);
      chk({7'h00, irq_oe}, 8'h00);
      rdchk(k < 8 ? `OFF_PEND0 : `OFF_PEND1, 8'h00);
    end
    // A request already latched must still let go of the pin
    enable(1'b0, 8'h04, 1'b1);
    pulse(1'b0, 8'h04);
    host_model_i.wr(`OFF_CTRL, 8'h40);
    @(posedge ref_clk);
    chk({7'h00, irq_oe}, 8'h00);
    host_model_i.wr(`OFF_PEND0, 8'h04);
    pulse(1'b0, 8'h04);
    @(posedge ref_clk);
    chk({7'h00, irq_oe}, 8'h00);
    rdchk(`OFF_PEND0, 8'h00);
    host_model_i.wr(`OFF_CTRL, 8'hBF);
    rdchk(`OFF_CTRL, 8'h9C);
    chk({4'h0, buf_sel, txsig, regsig, bersrc}, 8'h0F);
    serial_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({7'h00, regsig}, 8'h00);
    serial_mode <= 1'b0;
    host_model_i.wr(`OFF_CTRL, 8'h00);
    @(posedge ref_clk);
    chk({4'h0, buf_sel, txsig, regsig, bersrc}, 8'h00);
    host_model_i.wr(`OFF_PATTERN, 8'hA5);
    host_model_i.wr(`OFF_BITMASK, 8'hF0);
    host_model_i.wr(`OFF_ARM, 8'h02);
    host_model_i.wr(`OFF_ARM, 8'h03);
    rdchk(`OFF_PENDM, 8'h02);
    slot(8'h25, 1'b1);
    rdchk(`OFF_PENDM, 8'h02);
    slot(8'hAF, 1'b0);
    rdchk(`OFF_PENDM, 8'h02);
    slot(8'hAF, 1'b1);
    rdchk(`OFF_PENDM, 8'h01);
    rdchk(`OFF_VECTOR, 8'h02);
    host_model_i.wr(`OFF_PENDM, 8'h01);
    slot(8'hAF, 1'b1);
    rdchk(`OFF_PENDM, 8'h00);
    host_model_i.wr(`OFF_ARM, 8'h02);
    host_model_i.wr(`OFF_ARM, 8'h03);
    slot(8'hA0, 1'b1);
    rdchk(`OFF_PENDM, 8'h01);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdchk(`OFF_PENDM, 8'h00);
    // Reset mask is all zero, so any selected slot must match
    host_model_i.wr(`OFF_ARM, 8'h02);
    host_model_i.wr(`OFF_ARM, 8'h03);
    slot(8'h5A, 1'b1);
    rdchk(`OFF_PENDM, 8'h01);
    print_verdict();
  end
endmodule
